// ### core/tpts_params.svh
`ifndef TPTS_PARAMS_SVH
`define TPTS_PARAMS_SVH

// ----------------------------------------------------------------------
// register offsets (byte addresses, one word each)
// ----------------------------------------------------------------------
`define TPTS_REG_CTRL       8'h00
`define TPTS_REG_COUNT      8'h04
`define TPTS_REG_LAST_TAG   8'h08
`define TPTS_REG_STAMP_LO   8'h0C
`define TPTS_REG_STAMP_MID  8'h10
`define TPTS_REG_STAMP_HI   8'h14

// ----------------------------------------------------------------------
// control fields and reset values
// ----------------------------------------------------------------------
`define TPTS_CTRL_ONE_STEP_BIT    0
`define TPTS_CTRL_TRANSP_BIT      1
`define TPTS_CTRL_RESET           2'h0
`define TPTS_COUNT_RESET          16'h0000
`define TPTS_RDATA_RESET          32'h0000_0000

// ----------------------------------------------------------------------
// timer layout
// ----------------------------------------------------------------------
`define TPTS_TIMER_W        80
`define TPTS_TOD_NS_W       32
`define TPTS_TOD_SEC_W      48
`define TPTS_CORR_W         64
`define TPTS_CORR_FRAC_W    16
`define TPTS_TAG_W          16

// ----------------------------------------------------------------------
// stamp commands
// ----------------------------------------------------------------------
`define TPTS_CMD_NOP        2'h0
`define TPTS_CMD_ONE_STEP   2'h1
`define TPTS_CMD_TWO_STEP   2'h2
`define TPTS_CMD_RESERVED   2'h3

`endif

// ### core/tpts_pkg.sv
`include "tpts_params.svh"

package tpts_pkg;

    typedef enum logic [1:0] {
        TPTS_NOP      = `TPTS_CMD_NOP,
        TPTS_ONE_STEP = `TPTS_CMD_ONE_STEP,
        TPTS_TWO_STEP = `TPTS_CMD_TWO_STEP,
        TPTS_RSVD     = `TPTS_CMD_RESERVED
    } tpts_cmd_t;

    typedef enum logic {
        TPTS_IDLE,
        TPTS_FRAME
    } tpts_state_t;

    // time of day layout: seconds above nanoseconds
    typedef struct packed {
        logic [`TPTS_TOD_SEC_W-1:0] sec;
        logic [`TPTS_TOD_NS_W-1:0]  ns;
    } tpts_tod_t;

    // correction layout: sign, whole ns in 62:16, fraction in 15:0
    typedef struct packed {
        logic [15:0]                  pad;
        logic                         sign;
        logic [46:0]                  ns;
        logic [`TPTS_CORR_FRAC_W-1:0] frac;
    } tpts_corr_t;

    typedef struct packed {
        logic [`TPTS_TIMER_W-1:0] stamp;
        logic [`TPTS_TAG_W-1:0]   tag;
    } tpts_ret_t;

    typedef struct packed {
        logic [63:0] data;
        logic        valid;
        logic        sop;
        logic        eop;
    } tpts_beat_t;

endpackage : tpts_pkg

// ### core/tpts_return.sv
`timescale 1ns/1ps
`include "tpts_params.svh"

module tpts_return
    import tpts_pkg::*;
(
    input  wire logic      clk_i,
    input  wire logic      rst_n_i,
    input  wire logic      ce_i,
    input  wire logic      take_i,
    input  wire tpts_ret_t ret_i,
    output logic           valid_o,
    output tpts_ret_t      ret_o
);

    // ------------------------------------------------------------------
    // return register
    // ------------------------------------------------------------------
    // stamp and tag hold until the next return, so they are stable
    // in the valid cycle and readable afterwards
    tpts_ret_t ret_ff;
    logic      valid_ff;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            valid_ff <= 1'b0;
            ret_ff   <= '0;
        end else if (ce_i) begin
            valid_ff <= take_i;
            if (take_i) begin
                ret_ff <= ret_i;
            end
        end
    end

    assign valid_o = valid_ff;
    assign ret_o   = ret_ff;

endmodule // tpts_return

// ### core/tpts_top.sv
// Overview of operation
// - normal mode: low 32 ns, high 48 seconds
// - transparent: bits 62:16 ns, 15:0 fraction
// - valid marks a presented captured stamp
// - returned tag equals client's frame tag
// - stamp taken at frame start beat
// - returned stamp keeps the selected timer format
// - command 00: no stamp, frame untouched
// - command 01: stamp and insert into frame
// - command 10: stamp returned, frame untouched
// - command 11 behaves as no operation
// - insertion only while one-step enable set
// - transparent mode: timer is correction value
// - transparent insertion adds correction to field
// - tag returned with each stamped frame
//
// Design decisions made here: the address map and the strobed register port.
`timescale 1ns/1ps
`include "tpts_params.svh"

module tpts_top
    import tpts_pkg::*;
#(
    parameter int OFFSET_W = 8
) (
    input  wire logic                     CORE_CLK_I,
    input  wire logic                     ARST_N_I,
    input  wire logic                     CE_I,
    input  wire logic [7:0]               REG_ADDR_I,
    input  wire logic [31:0]              REG_WDATA_I,
    input  wire logic                     REG_WR_I,
    input  wire logic                     REG_RD_I,
    output logic      [31:0]              REG_RDATA_O,
    input  wire logic [`TPTS_TIMER_W-1:0] TX_TIMER_I,
    input  wire logic [63:0]              TX_DATA_I,
    input  wire logic                     TX_VALID_I,
    input  wire logic                     TX_SOP_I,
    input  wire logic                     TX_EOP_I,
    input  wire logic [1:0]               TX_STAMP_COMMAND_I,
    input  wire logic [`TPTS_TAG_W-1:0]   TX_TAG_I,
    input  wire logic [OFFSET_W-1:0]      TX_STAMP_OFFSET_I,
    output logic      [63:0]              TX_DATA_O,
    output logic                          TX_VALID_O,
    output logic                          TX_SOP_O,
    output logic                          TX_EOP_O,
    output logic                          TX_STAMP_VALID_O,
    output logic      [`TPTS_TAG_W-1:0]   TX_STAMP_TAG_O,
    output logic      [`TPTS_TIMER_W-1:0] TX_STAMP_O
);

    // ------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------
    logic [1:0]               ctrl_ff;
    logic [1:0]               nxt_ctrl;
    logic [15:0]              count_ff;
    logic [15:0]              nxt_count;
    logic [31:0]              rdata_ff;
    logic [31:0]              nxt_rdata;
    tpts_state_t              state_ff;
    tpts_state_t              nxt_state;
    logic [OFFSET_W-1:0]      idx_ff;
    logic [OFFSET_W-1:0]      off_ff;
    logic                     ins_ff;
    logic [`TPTS_TIMER_W-1:0] cap_ff;
    tpts_beat_t               out_ff;
    tpts_beat_t               nxt_out;

    wire logic                one_step_en;
    wire logic                transp_mode;
    wire logic                wr_ctrl;
    wire logic                wr_count;
    wire logic                beat;
    wire logic                sop_beat;
    wire tpts_cmd_t           cmd;
    wire logic                cmd_one;
    wire logic                cmd_two;
    wire logic                ret_take;
    wire logic                ins_act;
    wire logic [OFFSET_W-1:0] cur_idx;
    wire logic [OFFSET_W-1:0] cur_off;
    wire logic [OFFSET_W-1:0] off_next;
    wire logic                hit_first;
    wire logic                hit_second;
    wire logic [`TPTS_TIMER_W-1:0] fmt_stamp;
    wire logic [`TPTS_TIMER_W-1:0] cur_stamp;
    wire tpts_tod_t           tod_view;
    wire tpts_corr_t          corr_view;
    wire logic [63:0]         tod_first;
    wire logic [63:0]         tod_second;
    wire logic [63:0]         corr_sum;
    wire logic [63:0]         ins_data;
    wire tpts_ret_t           ret_in;
    wire tpts_ret_t           ret_out;
    wire logic                ret_valid;

    // ------------------------------------------------------------------
    // register bus decode
    // ------------------------------------------------------------------
    assign wr_ctrl     = REG_WR_I && (REG_ADDR_I == `TPTS_REG_CTRL);
    assign wr_count    = REG_WR_I && (REG_ADDR_I == `TPTS_REG_COUNT);
    assign one_step_en = ctrl_ff[`TPTS_CTRL_ONE_STEP_BIT];
    assign transp_mode = ctrl_ff[`TPTS_CTRL_TRANSP_BIT];
    assign nxt_ctrl    = wr_ctrl ? REG_WDATA_I[1:0] : ctrl_ff;

    // ------------------------------------------------------------------
    // command decode
    // ------------------------------------------------------------------
    // the command is only looked at on the first beat of a frame
    assign beat     = TX_VALID_I;
    assign sop_beat = TX_VALID_I && TX_SOP_I;
    assign cmd      = tpts_cmd_t'(TX_STAMP_COMMAND_I);
    assign cmd_one  = (cmd == TPTS_ONE_STEP);
    assign cmd_two  = (cmd == TPTS_TWO_STEP);
    // nop and the reserved code both fall outside cmd_one and cmd_two
    assign ret_take = sop_beat && (cmd_one || cmd_two);

    // ------------------------------------------------------------------
    // timer formatting
    // ------------------------------------------------------------------
    assign tod_view  = tpts_tod_t'(TX_TIMER_I);
    assign corr_view = tpts_corr_t'(TX_TIMER_I);
    // transparent mode keeps only the 64-bit correction, upper bits zero
    assign fmt_stamp = transp_mode ?
                       {16'h0000, corr_view.sign, corr_view.ns, corr_view.frac} :
                       {tod_view.sec, tod_view.ns};
    // timer is sampled as-is, it must already be in this domain
    assign cur_stamp = sop_beat ? fmt_stamp : cap_ff;

    // ------------------------------------------------------------------
    // frame position
    // ------------------------------------------------------------------
    assign cur_idx    = sop_beat ? '0 : idx_ff;
    assign cur_off    = sop_beat ? TX_STAMP_OFFSET_I : off_ff;
    assign off_next   = cur_off + OFFSET_W'(1);
    assign ins_act    = sop_beat ? (cmd_one && one_step_en) : ins_ff;
    assign hit_first  = ins_act && beat && (cur_idx == cur_off);
    // second word only matters for the 80-bit time of day field
    // an offset of all ones has no second word; the wrapped sum would hit word 0
    assign hit_second = ins_act && beat && !transp_mode && (cur_off != '1) &&
                        (cur_idx == off_next);

    // ------------------------------------------------------------------
    // one-step insertion
    // ------------------------------------------------------------------
    // time of day field spans two words, seconds first; a field that
    // runs past the end of frame is simply truncated
    assign tod_first  = cur_stamp[79:16];
    assign tod_second = {cur_stamp[15:0], TX_DATA_I[47:0]};
    // wrap-around of the correction sum is by design of the field
    assign corr_sum   = TX_DATA_I + cur_stamp[63:0];
    // far end has already folded its receive stamp in
    assign ins_data   = hit_first  ? (transp_mode ? corr_sum : tod_first) :
                        hit_second ? tod_second :
                        TX_DATA_I;

    assign nxt_out.data  = ins_data;
    assign nxt_out.valid = TX_VALID_I;
    assign nxt_out.sop   = TX_VALID_I && TX_SOP_I;
    assign nxt_out.eop   = TX_VALID_I && TX_EOP_I;

    // ------------------------------------------------------------------
    // frame tracking state
    // ------------------------------------------------------------------
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            TPTS_IDLE: begin
                if (sop_beat && !TX_EOP_I) begin
                    nxt_state = TPTS_FRAME;
                end
            end
            TPTS_FRAME: begin
                if (beat && TX_EOP_I && !TX_SOP_I) begin
                    nxt_state = TPTS_IDLE;
                end
            end
            default: begin
                nxt_state = TPTS_IDLE;
            end
        endcase
    end

    always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            state_ff <= TPTS_IDLE;
            idx_ff   <= '0;
            off_ff   <= '0;
            ins_ff   <= 1'b0;
            cap_ff   <= '0;
        end else if (CE_I) begin
            state_ff <= nxt_state;
            if (sop_beat) begin
                idx_ff <= OFFSET_W'(1);
                off_ff <= TX_STAMP_OFFSET_I;
                ins_ff <= cmd_one && one_step_en;
                cap_ff <= fmt_stamp;
            end else if (beat && state_ff == TPTS_FRAME) begin
                // saturate so a long frame cannot wrap onto the offset
                if (idx_ff != '1) begin
                    idx_ff <= idx_ff + OFFSET_W'(1);
                end
            end
            if (beat && TX_EOP_I && !TX_SOP_I) begin
                ins_ff <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // output beat pipeline
    // ------------------------------------------------------------------
    always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            out_ff <= '0;
        end else if (CE_I) begin
            out_ff <= nxt_out;
        end
    end

    assign TX_DATA_O  = out_ff.data;
    assign TX_VALID_O = out_ff.valid;
    assign TX_SOP_O   = out_ff.sop;
    assign TX_EOP_O   = out_ff.eop;

    // ------------------------------------------------------------------
    // stamp return
    // ------------------------------------------------------------------
    assign ret_in.stamp = fmt_stamp;
    assign ret_in.tag   = TX_TAG_I;

    tpts_return u_return (
        .clk_i   (CORE_CLK_I),
        .rst_n_i (ARST_N_I),
        .ce_i    (CE_I),
        .take_i  (ret_take),
        .ret_i   (ret_in),
        .valid_o (ret_valid),
        .ret_o   (ret_out)
    );

    assign TX_STAMP_VALID_O = ret_valid;
    assign TX_STAMP_TAG_O   = ret_out.tag;
    assign TX_STAMP_O       = ret_out.stamp;

    // ------------------------------------------------------------------
    // control and counter registers
    // ------------------------------------------------------------------
    // a stamp in the same cycle as a clear still counts
    assign nxt_count = ret_take ? (wr_count ? 16'h0001 : count_ff + 16'h0001) :
                       wr_count ? `TPTS_COUNT_RESET : count_ff;

    always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            ctrl_ff  <= `TPTS_CTRL_RESET;
            count_ff <= `TPTS_COUNT_RESET;
        end else if (CE_I) begin
            ctrl_ff  <= nxt_ctrl;
            count_ff <= nxt_count;
        end
    end

    // ------------------------------------------------------------------
    // read path
    // ------------------------------------------------------------------
    always_comb begin
        nxt_rdata = `TPTS_RDATA_RESET;
        if (!REG_RD_I) begin
            nxt_rdata = `TPTS_RDATA_RESET;
        end else if (REG_ADDR_I == `TPTS_REG_CTRL) begin
            nxt_rdata = {30'h0000_0000, ctrl_ff};
        end else if (REG_ADDR_I == `TPTS_REG_COUNT) begin
            nxt_rdata = {16'h0000, count_ff};
        end else if (REG_ADDR_I == `TPTS_REG_LAST_TAG) begin
            nxt_rdata = {16'h0000, ret_out.tag};
        end else if (REG_ADDR_I == `TPTS_REG_STAMP_LO) begin
            nxt_rdata = ret_out.stamp[31:0];
        end else if (REG_ADDR_I == `TPTS_REG_STAMP_MID) begin
            nxt_rdata = ret_out.stamp[63:32];
        end else if (REG_ADDR_I == `TPTS_REG_STAMP_HI) begin
            nxt_rdata = {16'h0000, ret_out.stamp[79:64]};
        end else begin
            nxt_rdata = `TPTS_RDATA_RESET;
        end
    end

    always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            rdata_ff <= `TPTS_RDATA_RESET;
        end else if (CE_I) begin
            rdata_ff <= nxt_rdata;
        end
    end

    assign REG_RDATA_O = rdata_ff;

endmodule // tpts_top

// ### dv/tpts_top_asserts.sv
`timescale 1ns/1ps

module tpts_top_checker
    import tpts_pkg::*;
#(
    parameter int OFFSET_W = 8
) (
    input wire logic                CORE_CLK_I,
    input wire logic                ARST_N_I,
    input wire logic                CE_I,
    input wire logic                REG_RD_I,
    input wire logic [31:0]         REG_RDATA_O,
    input wire logic [79:0]         TX_TIMER_I,
    input wire logic [63:0]         TX_DATA_I,
    input wire logic                TX_VALID_I,
    input wire logic                TX_SOP_I,
    input wire logic [1:0]          TX_STAMP_COMMAND_I,
    input wire logic [15:0]         TX_TAG_I,
    input wire logic [OFFSET_W-1:0] TX_STAMP_OFFSET_I,
    input wire logic [63:0]         TX_DATA_O,
    input wire logic                TX_VALID_O,
    input wire logic                TX_SOP_O,
    input wire logic                TX_STAMP_VALID_O,
    input wire logic [15:0]         TX_STAMP_TAG_O,
    input wire logic [79:0]         TX_STAMP_O
);
    default clocking dc @(posedge CORE_CLK_I); endclocking
    default disable iff (!ARST_N_I);

    wire        sop_in  = TX_VALID_I && TX_SOP_I;
    wire        stamped = CE_I && sop_in && ^TX_STAMP_COMMAND_I;
    wire [63:0] tm_lo   = TX_TIMER_I[63:0];

    stamp_valid_a: assert property (stamped |=> TX_STAMP_VALID_O)
        else $error("no stamp valid after stamped start beat");
    no_stamp_a: assert property (CE_I && !stamped |=> !TX_STAMP_VALID_O)
        else $error("stamp valid without stamped start beat");
    tag_match_a: assert property (stamped |=> TX_STAMP_TAG_O == $past(TX_TAG_I))
        else $error("returned tag differs from frame tag");
    stamp_fmt_a: assert property (stamped |=> TX_STAMP_O == $past(TX_TIMER_I) ||
        TX_STAMP_O == {16'h0000, $past(tm_lo)})
        else $error("returned stamp is not the start beat timer");
    stamp_hold_a: assert property (!TX_STAMP_VALID_O |->
        $stable(TX_STAMP_O) && $stable(TX_STAMP_TAG_O))
        else $error("stamp or tag moved without valid");
    beat_delay_a: assert property (CE_I |=> TX_VALID_O == $past(TX_VALID_I) &&
        TX_SOP_O == $past(sop_in))
        else $error("output beat framing not one cycle behind");
    pass_data_a: assert property (CE_I && sop_in &&
        (TX_STAMP_COMMAND_I != 2'h1 || TX_STAMP_OFFSET_I != '0) |=> TX_DATA_O == $past(TX_DATA_I))
        else $error("start word altered");
    rdata_idle_a: assert property (CE_I && !REG_RD_I |=> REG_RDATA_O == 32'h0000_0000)
        else $error("read data outside read answer cycle");

    two_step_c: cover property (stamped && TX_STAMP_COMMAND_I == 2'h2);
    one_step_c: cover property (stamped && TX_STAMP_COMMAND_I == 2'h1 ##1 TX_STAMP_VALID_O);
    rsvd_c: cover property (CE_I && sop_in && TX_STAMP_COMMAND_I == 2'h3);
endmodule // tpts_top_checker

bind tpts_top tpts_top_checker #(.OFFSET_W(OFFSET_W)) u_chk (
    .CORE_CLK_I(CORE_CLK_I), .ARST_N_I(ARST_N_I), .CE_I(CE_I), .REG_RD_I(REG_RD_I),
    .REG_RDATA_O(REG_RDATA_O), .TX_TIMER_I(TX_TIMER_I), .TX_DATA_I(TX_DATA_I),
    .TX_VALID_I(TX_VALID_I), .TX_SOP_I(TX_SOP_I), .TX_STAMP_COMMAND_I(TX_STAMP_COMMAND_I),
    .TX_TAG_I(TX_TAG_I), .TX_STAMP_OFFSET_I(TX_STAMP_OFFSET_I), .TX_DATA_O(TX_DATA_O),
    .TX_VALID_O(TX_VALID_O), .TX_SOP_O(TX_SOP_O), .TX_STAMP_VALID_O(TX_STAMP_VALID_O),
    .TX_STAMP_TAG_O(TX_STAMP_TAG_O), .TX_STAMP_O(TX_STAMP_O));

// ### dv/tpts_client.sv
`timescale 1ns/1ps

module tpts_client
    import tpts_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        ce_i,
    input  wire logic        go_i,
    input  wire logic [7:0]  len_i,
    input  wire logic [7:0]  gap_i,
    input  wire logic [63:0] base_i,
    output logic             busy_o,
    output tpts_beat_t       beat_o
);
    logic [7:0] left_ff;
    logic [7:0] k_ff;
    logic [7:0] gap_ff;

    assign busy_o = left_ff != 8'h00;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            left_ff <= 8'h00;
            k_ff    <= 8'h00;
            gap_ff  <= 8'h00;
            beat_o  <= '0;
        end else if (ce_i) begin
            if (busy_o && gap_ff == 8'h00) begin
                // field words arrive already corrected upstream
                beat_o.data  <= base_i + 64'(k_ff) * 64'h0101_0101_0101_0101;
                beat_o.valid <= 1'b1;
                beat_o.sop   <= k_ff == 8'h00;
                beat_o.eop   <= left_ff == 8'h01;
                k_ff         <= k_ff + 8'h01;
                left_ff      <= left_ff - 8'h01;
                gap_ff       <= gap_i;
            end else begin
                // idle lines churn so stale values never look valid
                beat_o.data  <= ~beat_o.data;
                beat_o.valid <= 1'b0;
                beat_o.sop   <= ~beat_o.sop;
                beat_o.eop   <= ~beat_o.eop;
                if (gap_ff != 8'h00) gap_ff <= gap_ff - 8'h01;
                if (go_i && !busy_o) begin
                    left_ff <= len_i;
                    k_ff    <= 8'h00;
                    gap_ff  <= 8'h00;
                end
            end
        end
    end
endmodule // tpts_client

// ### dv/tb.sv
`timescale 1ns/1ps
`include "tpts_params.svh"

module tb
    import tpts_pkg::*;
;
    logic        clk = 1'b0;
    logic        arst_n, ce, ce_rnd, ce_e, rd, wr, go, v_o, s_o, e_o, sv_o, busy;
    logic [7:0]  addr, off, len, gap;
    logic [31:0] wdata, rdata;
    logic [79:0] timer, tsop, stamp_o;
    logic [15:0] tag, tag_o;
    logic [1:0]  cmd, mode;
    logic [63:0] base, data_o;
    tpts_beat_t  beat;
    int          errors, comparisons, kout, exp_n, got_n, cyc;

    tpts_top #(.OFFSET_W(8)) u_dut (.CORE_CLK_I(clk), .ARST_N_I(arst_n), .CE_I(ce),
        .REG_ADDR_I(addr), .REG_WDATA_I(wdata), .REG_WR_I(wr), .REG_RD_I(rd),
        .REG_RDATA_O(rdata), .TX_TIMER_I(timer), .TX_DATA_I(beat.data),
        .TX_VALID_I(beat.valid), .TX_SOP_I(beat.sop), .TX_EOP_I(beat.eop),
        .TX_STAMP_COMMAND_I(cmd), .TX_TAG_I(tag), .TX_STAMP_OFFSET_I(off),
        .TX_DATA_O(data_o), .TX_VALID_O(v_o), .TX_SOP_O(s_o), .TX_EOP_O(e_o),
        .TX_STAMP_VALID_O(sv_o), .TX_STAMP_TAG_O(tag_o), .TX_STAMP_O(stamp_o));
    tpts_client u_client (.clk_i(clk), .rst_n_i(arst_n), .ce_i(ce), .go_i(go),
        .len_i(len), .gap_i(gap), .base_i(base), .busy_o(busy), .beat_o(beat));

    always #4 clk = ~clk;
    always @(posedge clk) timer <= {16'($urandom), $urandom, $urandom};
    always @(posedge clk) ce <= !ce_rnd || ($urandom_range(7) != 0);

    // ------------------------------------------------------------
    // expectations
    // ------------------------------------------------------------
    function automatic logic [63:0] exp_word(input int k);
        logic [63:0] w;
        w = base + 64'(k) * 64'h0101_0101_0101_0101;
        if (cmd == 2'h1 && mode[0] && k == int'(off)) w = mode[1] ? w + tsop[63:0] : tsop[79:16];
        if (cmd == 2'h1 && mode == 2'h1 && k == int'(off) + 1) w[63:48] = tsop[15:0];
        return w;
    endfunction

    function automatic logic [79:0] exp_stamp();
        return mode[1] ? {16'h0000, tsop[63:0]} : tsop;
    endfunction

    task automatic chk(input logic [79:0] got, input logic [79:0] exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        wr    <= 1'b1;
        addr  <= a;
        wdata <= d;
        @(posedge clk);
        wr    <= 1'b0;
    endtask

    task automatic reg_rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        rd   <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd   <= 1'b0;
        #1;
        chk(80'(rdata), 80'(exp));
    endtask

    task automatic close_out();
        $display("errors=%0d comparisons=%0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    // ------------------------------------------------------------
    // monitors
    // ------------------------------------------------------------
    always @(posedge clk) begin
        ce_e = ce;
        if (ce && beat.valid && beat.sop && ^cmd) begin
            tsop = timer;
            exp_n++;
        end
        cyc++;
        if (cyc == 6000) begin
            errors++;
            close_out();
        end
    end

    always @(negedge clk) begin
        if (ce_e && v_o) begin
            if (s_o) kout = 0;
            chk(80'(data_o), 80'(exp_word(kout)));
            chk(80'(e_o), 80'(kout == int'(len) - 1));
            kout++;
        end
        if (ce_e && sv_o) begin
            got_n++;
            chk(stamp_o, exp_stamp());
            chk(80'(tag_o), 80'(tag));
        end
    end

    // ------------------------------------------------------------
    // frame sequence
    // ------------------------------------------------------------
    task automatic send(input logic [1:0] c);
        @(posedge clk);
        cmd    <= c;
        tag    <= 16'($urandom);
        base   <= {$urandom, $urandom};
        off    <= 8'($urandom_range(2));
        len    <= 8'($urandom_range(4, 1));
        gap    <= 8'($urandom_range(1));
        go     <= 1'b1;
        ce_rnd = 1'b1;
        @(negedge clk);
        while (!busy) @(negedge clk);
        @(posedge clk);
        go <= 1'b0;
        @(negedge clk);
        while (busy) @(negedge clk);
        ce_rnd = 1'b0;
        repeat (4) @(posedge clk);
        chk(80'(got_n), 80'(exp_n));
        chk(80'(kout), 80'(len));
        reg_rd(`TPTS_REG_COUNT, 32'(exp_n % 65536));
        if (^c) begin
            reg_rd(`TPTS_REG_LAST_TAG, {16'h0000, tag});
            reg_rd(`TPTS_REG_STAMP_LO, 32'(exp_stamp()));
            reg_rd(`TPTS_REG_STAMP_MID, 32'(exp_stamp() >> 32));
            reg_rd(`TPTS_REG_STAMP_HI, 32'(exp_stamp() >> 64));
        end
    endtask

    initial begin
        void'($urandom(32'h48b9_74fc));
        {arst_n, ce_rnd, rd, wr, go} = '0;
        {addr, wdata, cmd, tag, off, len, gap, base, mode} = '0;
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        reg_rd(`TPTS_REG_CTRL, 32'h0000_0000);
        reg_rd(`TPTS_REG_COUNT, 32'h0000_0000);
        reg_rd(8'h20, 32'h0000_0000);
        reg_wr(`TPTS_REG_LAST_TAG, 32'h0000_ffff);
        reg_rd(`TPTS_REG_LAST_TAG, 32'h0000_0000);
        for (int m = 0; m < 4; m++) begin
            mode = 2'(m);
            reg_wr(`TPTS_REG_CTRL, 32'(m));
            reg_rd(`TPTS_REG_CTRL, 32'(m));
            for (int i = 0; i < 12; i++) send(2'(i % 4));
        end
        reg_wr(`TPTS_REG_COUNT, 32'h0000_0000);
        reg_rd(`TPTS_REG_COUNT, 32'h0000_0000);
        close_out();
    end
endmodule // tb
